// *** src/evpc_pkg.sv ***
// package: constants and types for the pilot state controller
package evpc_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned PWM_HZ         = 1_000;
	localparam int unsigned PERIOD_CYC     = CLK_HZ / PWM_HZ;
	localparam int unsigned SELFTEST_US    = 100;
	localparam int unsigned SELFTEST_CYC   = (SELFTEST_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
		SELFTEST_US * (CLK_HZ / 1_000_000);
	localparam int unsigned STABLE_PERIODS = 4;
	// duty in tenths of a percent, from amps
	localparam int unsigned DUTY_MAX_TENTHS = 1000;
	localparam int unsigned AMP_LOW_MIN     = 6;
	localparam int unsigned AMP_LOW_MAX     = 51;
	localparam int unsigned AMP_HIGH_MAX    = 80;
	localparam int unsigned HIGH_OFFSET_TEN = 640;
	// adc thresholds, 10-bit code for a 0..12 V high level (sensed through divider)
	localparam logic [9:0] TH_12_9 = 10'h349;
	localparam logic [9:0] TH_9_6  = 10'h25d;
	localparam logic [9:0] TH_6_3  = 10'h177;
	localparam logic [9:0] TH_3_0  = 10'h08c;
	localparam logic [9:0] TH_NEG  = 10'h040;

	// sensed pilot class
	typedef enum logic [2:0] {
		LVL_12,
		LVL_9,
		LVL_6,
		LVL_3,
		LVL_0,
		LVL_NOHIGH
	} evpc_lvl_type;

	// controller states
	typedef enum logic [2:0] {
		ST_SELFTEST,
		ST_IDLE,
		ST_CONN,
		ST_CHARGE,
		ST_VENT,
		ST_ERROR,
		ST_UNKNOWN
	} evpc_state_type;
endpackage

// *** src/evpc_cls_if.sv ***
// interface: classifier result to the state controller
interface evpc_cls_if;
	evpc_pkg::evpc_lvl_type level;
	logic                   valid;
	logic                   neg_ok;
	modport cls (output level, output valid, output neg_ok);
	modport ctl (input level, input valid, input neg_ok);
endinterface

// *** src/evpc_classifier.sv ***
// module: pilot adc sampler and debounced level classifier
module evpc_classifier #(
	parameter int unsigned STABLE = evpc_pkg::STABLE_PERIODS
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	// adc sample and pwm phase
	input  wire logic [9:0] adc_i,
	input  wire logic       adc_valid_i,
	input  wire logic       phase_high_i,
	input  wire logic       period_end_i,
	input  wire logic       modulating_i,
	// result
	evpc_cls_if.cls         res
);
	evpc_pkg::evpc_lvl_type cand_reg, level_reg;
	logic [9:0]             hi_max_reg;
	logic                   hi_seen_reg, lo_neg_reg, neg_ok_reg, valid_reg;
	logic [7:0]             stab_reg;
	evpc_pkg::evpc_lvl_type cls_next;

	// high-phase peak and low-phase negative check over one period
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hi_max_reg  <= 10'h000;
			hi_seen_reg <= 1'b0;
			lo_neg_reg  <= 1'b0;
		end else if (ce_i) begin
			if (period_end_i) begin
				// a sample on the boundary opens the next period rather than being lost
				hi_max_reg  <= (adc_valid_i && phase_high_i) ? adc_i : 10'h000;
				hi_seen_reg <= adc_valid_i && phase_high_i;
				lo_neg_reg  <= adc_valid_i && !phase_high_i && (adc_i < evpc_pkg::TH_NEG);
			end else if (adc_valid_i && phase_high_i) begin
				// high level only measured while driving high
				if (adc_i > hi_max_reg) hi_max_reg <= adc_i;
				hi_seen_reg <= 1'b1;
			end else if (adc_valid_i && !phase_high_i && adc_i < evpc_pkg::TH_NEG) begin
				lo_neg_reg <= 1'b1;
			end
		end
	end

	// midway thresholds between nominal levels
	always_comb begin
		if (!hi_seen_reg || hi_max_reg < evpc_pkg::TH_NEG)
			cls_next = (lo_neg_reg || !modulating_i) ? evpc_pkg::LVL_NOHIGH : evpc_pkg::LVL_0;
		else if (hi_max_reg >= evpc_pkg::TH_12_9) cls_next = evpc_pkg::LVL_12;
		else if (hi_max_reg >= evpc_pkg::TH_9_6)  cls_next = evpc_pkg::LVL_9;
		else if (hi_max_reg >= evpc_pkg::TH_6_3)  cls_next = evpc_pkg::LVL_6;
		else if (hi_max_reg >= evpc_pkg::TH_3_0)  cls_next = evpc_pkg::LVL_3;
		else cls_next = evpc_pkg::LVL_0;
	end

	// debounce: a class must repeat for STABLE periods before it is reported
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cand_reg   <= evpc_pkg::LVL_12;
			level_reg  <= evpc_pkg::LVL_12;
			stab_reg   <= 8'h00;
			neg_ok_reg <= 1'b0;
			valid_reg  <= 1'b0;
		end else if (ce_i && period_end_i) begin
			neg_ok_reg <= lo_neg_reg || !modulating_i;
			if (cls_next != cand_reg) begin
				cand_reg <= cls_next;
				stab_reg <= 8'h00;
			end else if (stab_reg < 8'(STABLE - 1)) begin
				stab_reg <= stab_reg + 8'h01;
			end else begin
				level_reg <= cand_reg;
				valid_reg <= 1'b1;
			end
		end
	end

	assign res.level  = level_reg;
	assign res.valid  = valid_reg;
	assign res.neg_ok = neg_ok_reg;
endmodule

// *** src/evpc_top.sv ***
// module: control-pilot state controller for a conductive ev supply unit
// Summary of operation
// - self test completes before offering any power
// - idle: pilot constant high, no modulation
// - 9 V sensed: connected, start duty-coded pwm
// - connected: energize supply relays with pwm
// - back to 12 V: drop relays, go idle
// - low-power charging still charging; only unplug or an error condition ends
// - error condition removes power to the vehicle
// - relays open unless actively driven while connected, charging or venting
// - sample pilot level through adc continuously after self test
// - indicators flag ground-fault and pilot errors
// - bipolar pilot; negative level checked under load
// - pwm at fixed 1 kHz when connected
// - duty from amps by two linear laws
// - recognise 3 V vent, 0 V error, unknown error
module evpc_top #(
	parameter int unsigned SELFTEST_CYC = evpc_pkg::SELFTEST_CYC,
	parameter int unsigned PERIOD_CYC   = evpc_pkg::PERIOD_CYC,
	parameter int unsigned STABLE       = evpc_pkg::STABLE_PERIODS
) (
	// clock, reset, enable
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	// configuration and status inputs
	input  wire logic [6:0] rated_amps_i,
	input  wire logic       selftest_ok_i,
	input  wire logic       gfault_i,
	// pilot adc
	input  wire logic [9:0] adc_i,
	input  wire logic       adc_valid_i,
	output logic            adc_start_o,
	// pilot drive: high selects +12 V, low selects -12 V
	output logic            pilot_pos_o,
	// relays and indicators
	output logic            relay_on_o,
	output logic            led_gfault_o,
	output logic            led_pilot_o,
	output logic [2:0]      state_o
);
	evpc_pkg::evpc_state_type state_reg, state_next;
	logic [31:0] st_cnt_reg;
	logic [15:0] ph_cnt_reg;
	logic [9:0]  duty_tenths;
	logic [15:0] high_cyc;
	logic        period_end, modulating, pilot_reg, relay_reg;
	logic        led_gf_reg, led_pl_reg, adc_reg;
	evpc_cls_if  cls ();

	// duty in tenths of percent; above the top range the pwm saturates at 96 %
	always_comb begin
		if (rated_amps_i < 7'(evpc_pkg::AMP_LOW_MIN))
			duty_tenths = 10'((evpc_pkg::AMP_LOW_MIN * 100) / 6);
		else if (rated_amps_i <= 7'(evpc_pkg::AMP_LOW_MAX))
			duty_tenths = 10'((32'(rated_amps_i) * 100) / 6);
		else if (rated_amps_i <= 7'(evpc_pkg::AMP_HIGH_MAX))
			duty_tenths = 10'(32'(rated_amps_i) * 4 + evpc_pkg::HIGH_OFFSET_TEN);
		else
			duty_tenths = 10'(evpc_pkg::AMP_HIGH_MAX * 4 + evpc_pkg::HIGH_OFFSET_TEN);
	end
	assign high_cyc = 16'((32'(duty_tenths) * PERIOD_CYC) / evpc_pkg::DUTY_MAX_TENTHS);

	// fixed period counter, runs always so idle level is also sampled each period
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) ph_cnt_reg <= 16'h0000;
		else if (ce_i) ph_cnt_reg <= period_end ? 16'h0000 : ph_cnt_reg + 16'h0001;
	end
	assign period_end = (ph_cnt_reg == 16'(PERIOD_CYC - 1));
	assign modulating = (state_reg == evpc_pkg::ST_CONN) ||
		(state_reg == evpc_pkg::ST_CHARGE) || (state_reg == evpc_pkg::ST_VENT);

	// pilot drive; error state pulls the line low for safety
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) pilot_reg <= 1'b1;
		else if (ce_i) begin
			if (modulating) pilot_reg <= (ph_cnt_reg < high_cyc);
			else if (state_reg == evpc_pkg::ST_ERROR) pilot_reg <= 1'b0;
			else pilot_reg <= 1'b1;
		end
	end

	// adc conversion request once per cycle in every state except self test
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) adc_reg <= 1'b0;
		else if (ce_i) adc_reg <= (state_reg != evpc_pkg::ST_SELFTEST);
	end

	evpc_classifier #(
		.STABLE(STABLE)
	) u_cls (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.adc_i       (adc_i),
		.adc_valid_i (adc_valid_i),
		.phase_high_i(pilot_reg),
		.period_end_i(period_end),
		.modulating_i(modulating),
		.res         (cls.cls)
	);

	// next-state decision from debounced level
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			evpc_pkg::ST_SELFTEST: begin
				if (st_cnt_reg >= 32'(SELFTEST_CYC) && selftest_ok_i)
					state_next = evpc_pkg::ST_IDLE;
			end
			evpc_pkg::ST_IDLE: begin
				if (cls.valid && cls.level == evpc_pkg::LVL_9)
					state_next = evpc_pkg::ST_CONN;
				else if (cls.valid && cls.level == evpc_pkg::LVL_0)
					state_next = evpc_pkg::ST_ERROR;
			end
			evpc_pkg::ST_CONN, evpc_pkg::ST_CHARGE, evpc_pkg::ST_VENT: begin
				// level changes, a ground fault or a missing negative level move the state; low current draw is ignored
				if (gfault_i) state_next = evpc_pkg::ST_ERROR;
				else if (cls.valid) begin
					case (cls.level)
						evpc_pkg::LVL_12:     state_next = evpc_pkg::ST_IDLE;
						evpc_pkg::LVL_9:      state_next = evpc_pkg::ST_CONN;
						evpc_pkg::LVL_6:      state_next = evpc_pkg::ST_CHARGE;
						evpc_pkg::LVL_3:      state_next = evpc_pkg::ST_VENT;
						evpc_pkg::LVL_0:      state_next = evpc_pkg::ST_ERROR;
						evpc_pkg::LVL_NOHIGH: state_next = evpc_pkg::ST_UNKNOWN;
						default:              state_next = evpc_pkg::ST_ERROR;
					endcase
					if (!cls.neg_ok) state_next = evpc_pkg::ST_ERROR;
				end
			end
			evpc_pkg::ST_ERROR, evpc_pkg::ST_UNKNOWN: begin
				// recover only once the line reads unplugged
				if (!gfault_i && cls.valid && cls.level == evpc_pkg::LVL_12)
					state_next = evpc_pkg::ST_IDLE;
			end
			default: state_next = evpc_pkg::ST_ERROR;
		endcase
	end

	// state register and self-test timer
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg  <= evpc_pkg::ST_SELFTEST;
			st_cnt_reg <= 32'h0000_0000;
		end else if (ce_i) begin
			state_reg <= state_next;
			if (state_reg == evpc_pkg::ST_SELFTEST && st_cnt_reg < 32'(SELFTEST_CYC))
				st_cnt_reg <= st_cnt_reg + 32'h0000_0001;
		end
	end

	// relays closed only while in the connected, charging or vent state with no ground fault; reset opens them
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) relay_reg <= 1'b0;
		else if (ce_i) relay_reg <= modulating && !gfault_i;
	end

	// error indicators
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			led_gf_reg <= 1'b0;
			led_pl_reg <= 1'b0;
		end else if (ce_i) begin
			led_gf_reg <= gfault_i;
			led_pl_reg <= (state_reg == evpc_pkg::ST_ERROR) ||
				(state_reg == evpc_pkg::ST_UNKNOWN);
		end
	end

	assign pilot_pos_o  = pilot_reg;
	assign relay_on_o   = relay_reg;
	assign led_gfault_o = led_gf_reg;
	assign led_pilot_o  = led_pl_reg;
	assign adc_start_o  = adc_reg;
	assign state_o      = state_reg;

	// guards on what the block shows the vehicle and the relays
	chk_selftest_no_power: assert property (@(posedge clk_i) disable iff (rst_i)
		state_reg == evpc_pkg::ST_SELFTEST |-> !relay_on_o && pilot_pos_o)
		else $error("power offered during self test");
	chk_idle_steady: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && state_reg == evpc_pkg::ST_IDLE ##1 state_reg == evpc_pkg::ST_IDLE
		|-> pilot_pos_o)
		else $error("pilot modulated while idle");
	chk_conn_relay: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && state_reg == evpc_pkg::ST_CONN && !gfault_i |=> relay_on_o)
		else $error("relay not closed when connected");
	chk_unplug_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && modulating && cls.valid && cls.level == evpc_pkg::LVL_12 && cls.neg_ok
		&& !gfault_i |=> state_reg == evpc_pkg::ST_IDLE
		##1 (!relay_on_o || !$past(ce_i)))
		else $error("unplug did not end session");
	chk_gfault_cut: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && gfault_i |=> !relay_on_o)
		else $error("relay stayed closed on fault");
	chk_error_open: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && (state_reg == evpc_pkg::ST_ERROR || state_reg == evpc_pkg::ST_UNKNOWN)
		|=> !relay_on_o)
		else $error("relay closed in an error state");
	chk_relay_safe: assert property (@(posedge clk_i) disable iff (rst_i)
		relay_on_o |-> $past(modulating))
		else $error("relay closed outside charging");
	chk_idle_open: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && state_reg == evpc_pkg::ST_IDLE |=> !relay_on_o)
		else $error("relay closed while idle");
	chk_pilot_led: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && state_reg == evpc_pkg::ST_ERROR |=> led_pilot_o)
		else $error("pilot error not flagged");
	// the drive lags the counter by one edge, so the new period shows high one edge later
	chk_conn_pwm: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && modulating && ph_cnt_reg == 16'(PERIOD_CYC - 1) ##1
		ce_i && modulating && high_cyc != 16'h0000 |=> pilot_pos_o)
		else $error("pwm period start not high");
	chk_vent_state: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && state_reg == evpc_pkg::ST_CHARGE && cls.valid && cls.neg_ok && !gfault_i
		&& cls.level == evpc_pkg::LVL_3 |=> state_reg == evpc_pkg::ST_VENT)
		else $error("3 V level not taken as ventilation");
endmodule

// *** verification/evpc_vehicle.sv ***
// vehicle model: answers the pilot drive with adc codes for its chosen load
module evpc_vehicle (
	// clock
	input  wire logic       clk_i,
	// pilot drive and conversion request
	input  wire logic       pilot_pos_i,
	input  wire logic       adc_start_i,
	// load: 0 none, 1 connect, 2 charge, 3 vent, 4 short, 5 no high; diode lost when low
	input  wire logic [2:0] load_i,
	input  wire logic       diode_ok_i,
	// adc answer
	output logic [9:0]      adc_o,
	output logic            adc_valid_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] high_code;

	// sensed high level for each load
	always_comb begin
		case (load_i)
			3'h0: high_code = 10'h3c0;
			3'h1: high_code = 10'h2d0;
			3'h2: high_code = 10'h1e0;
			3'h3: high_code = 10'h100;
			3'h4: high_code = 10'h060;
			default: high_code = 10'h010;
		endcase
	end

	initial begin
		adc_o = 10'h000;
		adc_valid_o = 1'b0;
	end

	// without a request the code toggles, so a stale value never reads as good
	always @(negedge clk_i) begin
		adc_valid_o <= adc_start_i;
		if (!adc_start_i)
			adc_o <= ~adc_o;
		else if (pilot_pos_i)
			adc_o <= high_code;
		else if (load_i == 3'h4 || !diode_ok_i)
			adc_o <= high_code;
		else
			adc_o <= 10'h000;
	end
endmodule

// *** verification/tb_top.sv ***
// testbench: drives the controller through its connection states
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int P = 100;
	localparam int ST = 4;
	logic       clk_i = 1'b0;
	logic       rst_i;
	logic       ce_i;
	logic [6:0] rated_amps_i;
	logic       selftest_ok_i;
	logic       gfault_i;
	logic [9:0] adc;
	logic       adc_valid;
	logic       adc_start_o;
	logic       pilot_pos_o;
	logic       relay_on_o;
	logic       led_gfault_o;
	logic       led_pilot_o;
	logic [2:0] state_o;
	logic [2:0] load;
	logic       diode_ok;
	logic [2:0] exp_q[$];
	logic [31:0] rnd = 32'h00000026;
	int         err_count = 0;
	int         tests_run = 0;
	int         hi;
	int         rises;
	int         amps;
	logic [5:0] snap;

	evpc_top #(.SELFTEST_CYC(ST), .PERIOD_CYC(P), .STABLE(2)) evpc_top_i (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .rated_amps_i(rated_amps_i),
		.selftest_ok_i(selftest_ok_i), .gfault_i(gfault_i), .adc_i(adc),
		.adc_valid_i(adc_valid), .adc_start_o(adc_start_o), .pilot_pos_o(pilot_pos_o),
		.relay_on_o(relay_on_o), .led_gfault_o(led_gfault_o), .led_pilot_o(led_pilot_o),
		.state_o(state_o));
	evpc_vehicle evpc_vehicle_i (.clk_i(clk_i), .pilot_pos_i(pilot_pos_o),
		.adc_start_i(adc_start_o), .load_i(load), .diode_ok_i(diode_ok),
		.adc_o(adc), .adc_valid_o(adc_valid));

	// 10 MHz clock
	initial begin
		forever #50 clk_i = ~clk_i;
	end

	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] expv);
		tests_run++;
		if (seen !== expv) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// note the state asked for, change the load, wait bounded for the move
	task automatic go(input logic [2:0] ld, input logic [2:0] st);
		int n;
		exp_q.push_back(st);
		load = ld;
		n = 0;
		while (state_o !== st && n < 2000) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 2000) begin
			err_count++;
			end_of_test();
		end
		repeat (2) @(negedge clk_i);
	endtask

	// high cycles and rising edges over one pwm period
	task automatic measure();
		logic last;
		hi = 0;
		rises = 0;
		last = pilot_pos_o;
		repeat (P) begin
			@(negedge clk_i);
			hi += int'(pilot_pos_o);
			rises += int'(pilot_pos_o && !last);
			last = pilot_pos_o;
		end
	endtask

	// second reset: self test must run its full count again before idle
	task automatic restart();
		int n;
		load = 3'h0;
		diode_ok = 1'b1;
		gfault_i = 1'b0;
		exp_q.push_back(3'h0);
		exp_q.push_back(3'h1);
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		n = 0;
		while (state_o !== 3'h1 && n < 2000) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 2000) begin
			err_count++;
			end_of_test();
		end
		check(16'(n), 16'(ST + 1));
	endtask

	// watcher: every state change takes the oldest note
	initial begin : watch
		logic [2:0] last;
		last = 3'h0;
		forever begin
			@(negedge clk_i);
			if (state_o !== last) begin
				if (exp_q.size() == 0)
					check(16'(state_o), 16'h7);
				else
					check(16'(state_o), 16'(exp_q.pop_front()));
				last = state_o;
			end
		end
	end

	// main sequence, inputs changed at the falling edge
	initial begin
		rst_i = 1'b1;
		rated_amps_i = 7'h20;
		selftest_ok_i = 1'b0;
		ce_i = 1'b1;
		gfault_i = 1'b0;
		load = 3'h0;
		diode_ok = 1'b1;
		repeat (8) @(negedge clk_i);
		check(16'({state_o, relay_on_o, pilot_pos_o}), 16'h01);
		rst_i = 1'b0;
		repeat (20) @(negedge clk_i);
		check(16'(state_o), 16'h0);
		selftest_ok_i = 1'b1;
		go(3'h0, 3'h1);
		measure();
		check(16'(hi), 16'(P));
		check(16'(adc_start_o), 16'h1);
		go(3'h1, 3'h2);
		check(16'(relay_on_o), 16'h1);
		for (int i = 0; i < 6; i++) begin
			rnd = xorshift(rnd);
			amps = (i == 0) ? 6 : (i == 1) ? 51 : (i == 2) ? 52 : (i == 3) ? 80 :
				(i == 4) ? 90 : int'(rnd[6:0]);
			rated_amps_i = 7'(amps);
			// ratings outside 6..80 A clamp to the end-point duties
			amps = (amps < 6) ? 6 : (amps > 80) ? 80 : amps;
			repeat (2 * P) @(negedge clk_i);
			measure();
			check(16'(hi), 16'(((amps <= 51) ? amps * 100 / 6 : amps * 4 + 640) * P / 1000));
			check(16'(rises), 16'h1);
		end
		go(3'h2, 3'h3);
		repeat (10 * P) @(negedge clk_i);
		check(16'({state_o, relay_on_o}), 16'h7);
		// enable low: nothing moves, not even when the vehicle unplugs meanwhile
		snap = {state_o, relay_on_o, pilot_pos_o, adc_start_o};
		ce_i = 1'b0;
		load = 3'h0;
		repeat (3 * P) @(negedge clk_i);
		check(16'({state_o, relay_on_o, pilot_pos_o, adc_start_o}), 16'(snap));
		// restore the load a cycle before waking so no unplugged code is sampled
		load = 3'h2;
		@(negedge clk_i);
		ce_i = 1'b1;
		go(3'h3, 3'h4);
		go(3'h0, 3'h1);
		check(16'(relay_on_o), 16'h0);
		go(3'h1, 3'h2);
		diode_ok = 1'b0;
		go(3'h1, 3'h5);
		check(16'({relay_on_o, led_pilot_o, pilot_pos_o}), 16'h2);
		restart();
		go(3'h1, 3'h2);
		gfault_i = 1'b1;
		go(3'h1, 3'h5);
		check(16'({relay_on_o, led_gfault_o}), 16'h1);
		restart();
		go(3'h1, 3'h2);
		go(3'h4, 3'h5);
		restart();
		go(3'h1, 3'h2);
		go(3'h5, 3'h6);
		check(16'({relay_on_o, led_pilot_o}), 16'h1);
		end_of_test();
	end
endmodule
